// ---- fslk_pkg.sv ----
// constants and carrier types for the flash sector lock and status block
package fslk_pkg;
    // ------------------------------------------------------------------
    // lock map geometry
    // ------------------------------------------------------------------
    localparam int          NUM_UNITS     = 4126;
    localparam int          ADDR_W        = 28;
    localparam int          UNIT_W        = 13;
    localparam int          SECT_LSB      = 12;
    localparam int          SECT_W        = 4;
    localparam int          BLK_LSB       = 16;
    localparam int          BLK_W         = 12;
    localparam int          EDGE_SECTORS  = 16;
    localparam int          MID_BASE      = 32;
    // ------------------------------------------------------------------
    // lock byte values and opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0]  LOCK_OFF      = 8'h00;
    localparam logic [7:0]  LOCK_ON       = 8'hFF;
    localparam logic [7:0]  OP_VOL_READ   = 8'hE0;
    localparam logic [7:0]  OP_VOL_WRITE  = 8'hE1;
    localparam logic [7:0]  OP_NVOL_READ  = 8'hE2;
    localparam logic [7:0]  OP_NVOL_SET   = 8'hE3;
    localparam logic [7:0]  OP_NVOL_CLEAR = 8'hE4;
    localparam logic [7:0]  OP_VOL_CLRALL = 8'h98;
    localparam logic [7:0]  OP_VOL_SETALL = 8'h7E;
    // ------------------------------------------------------------------
    // status byte selection and writable masks
    // ------------------------------------------------------------------
    localparam logic [1:0]  SEL_SR1       = 2'h0;
    localparam logic [1:0]  SEL_SR2       = 2'h1;
    localparam logic [1:0]  SEL_SR3       = 2'h2;
    localparam logic [7:0]  SR1_WR_MASK   = 8'hFC;
    localparam logic [7:0]  SR2_WR_MASK   = 8'h41;
    localparam logic [7:0]  SR2_OTP_MASK  = 8'h38;
    localparam logic [7:0]  SR3_WR_MASK   = 8'h13;
    localparam logic [7:0]  NV_SR_RESET   = 8'h00;
    // quad enable reads one even while reset is held
    localparam logic [23:0] STATUS_RESET  = 24'h000200;
    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        logic [7:0]        op;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } fslk_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] sel;
        logic [7:0] data;
    } fslk_srwr_t;
endpackage : fslk_pkg

// ---- fslk_unit_map.sv ----
// maps a flash byte address onto its lock unit index
`timescale 1ns/100ps
module fslk_unit_map #(
    parameter int LAST_BLOCK = 4095
) (
    // address in
    input  wire logic [fslk_pkg::ADDR_W-1:0] addr_in,
    // unit index out
    output wire logic [fslk_pkg::UNIT_W-1:0] unit_out
);
    wire logic [fslk_pkg::BLK_W-1:0]  blk;
    wire logic [fslk_pkg::SECT_W-1:0] sect;
    wire logic [fslk_pkg::UNIT_W-1:0] edge_top;
    wire logic [fslk_pkg::UNIT_W-1:0] mid_idx;

    // the last block must sit above block one and fit the block field
    if (LAST_BLOCK < 2 || LAST_BLOCK >= (1 << fslk_pkg::BLK_W)) begin : g_chk
        $error("fslk_unit_map: last block out of range");
    end

    assign blk      = addr_in[fslk_pkg::BLK_LSB +: fslk_pkg::BLK_W];
    assign sect     = addr_in[fslk_pkg::SECT_LSB +: fslk_pkg::SECT_W];
    // end blocks lock per sector, middle blocks per block
    assign edge_top = fslk_pkg::UNIT_W'(fslk_pkg::EDGE_SECTORS) + fslk_pkg::UNIT_W'(sect);
    assign mid_idx  = fslk_pkg::UNIT_W'(fslk_pkg::MID_BASE - 1) + fslk_pkg::UNIT_W'(blk);
    assign unit_out = (blk == '0) ? fslk_pkg::UNIT_W'(sect) :
                      (blk == fslk_pkg::BLK_W'(LAST_BLOCK)) ? edge_top : mid_idx;
endmodule : fslk_unit_map

// ---- fslk_core.sv ----
// sector and block lock arrays plus the three status bytes
// Operation
// - there are 4126 volatile lock units, each reading 00h when open and FFh when locked.
// - a volatile lock write with data other than 00h or FFh is dropped and the latch stays set.
// - reset loads every volatile lock from the default bit of the persistent config register.
// - the host reads one nonvolatile lock by sector or block address with E2h.
// - E3h sets only the addressed nonvolatile lock.
// - E4h clears every nonvolatile lock at once.
// - the lowest and highest blocks lock per 4KB sector, the 4094 middle blocks per block.
// - nonvolatile locks start at 00h, and a locked unit refuses program and erase.
// - status byte one holds guard low, five block protect bits, write latch and busy.
// - status byte two holds suspend flags, complement, three OTP locks, quad one, guard high.
// - status byte three holds power-up width, current width and two dummy select bits.
// - with both guard bits clear, status and nonvolatile writes need the write latch set.
// - while the write latch is clear, every write, program and erase is refused.
// - E0h reads and E1h writes one volatile lock, 98h clears all and 7Eh sets all.
`timescale 1ns/100ps
module fslk_core #(
    parameter int NUM_UNITS  = fslk_pkg::NUM_UNITS,
    parameter int LAST_BLOCK = 4095
) (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    // decoded host commands
    input  wire fslk_pkg::fslk_cmd_t         cmd_in,
    input  wire fslk_pkg::fslk_srwr_t        srwr_in,
    input  wire logic                        write_enable_in,
    input  wire logic                        write_disable_in,
    // device state feeding status, the volatile lock reset default and the wp pin guard
    input  wire logic                        volatile_lock_default_in,
    input  wire logic                        busy_in,
    input  wire logic                        erase_susp_in,
    input  wire logic                        prog_susp_in,
    input  wire logic                        addr4_in,
    input  wire logic                        wp_n_in,
    // program and erase check
    input  wire logic                        pe_req_in,
    input  wire logic [fslk_pkg::ADDR_W-1:0] pe_addr_in,
    output logic                             pe_grant_out,
    output logic                             pe_reject_out,
    // read answers
    output logic [7:0]                       rd_data_out,
    output logic                             rd_valid_out,
    output logic [23:0]                      status_out
);
    // the unit index must also reach every unit of the map
    if (NUM_UNITS != fslk_pkg::MID_BASE + LAST_BLOCK - 1 ||
        NUM_UNITS > (1 << fslk_pkg::UNIT_W)) begin : g_chk
        $error("fslk_core: unit count does not match block count");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [NUM_UNITS-1:0]        volatile_lock_q;
    logic [NUM_UNITS-1:0]        nonvolatile_lock_q;
    logic                        write_enable_latch_q;
    logic [7:0]                  sr1_nv_q;
    logic [7:0]                  sr2_nv_q;
    logic [7:0]                  sr3_nv_q;
    logic                        wp_meta_q;
    logic                        wp_sync_q;
    wire logic [fslk_pkg::UNIT_W-1:0] cmd_unit;
    wire logic [fslk_pkg::UNIT_W-1:0] pe_unit;

    fslk_unit_map #(.LAST_BLOCK(LAST_BLOCK)) u_cmd_map (
        .addr_in  (cmd_in.addr),
        .unit_out (cmd_unit)
    );
    fslk_unit_map #(.LAST_BLOCK(LAST_BLOCK)) u_pe_map (
        .addr_in  (pe_addr_in),
        .unit_out (pe_unit)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire logic status_guard_low  = sr1_nv_q[7];
    wire logic status_guard_high = sr2_nv_q[0];
    wire logic is_vol_wr    = cmd_in.valid && cmd_in.op == fslk_pkg::OP_VOL_WRITE;
    wire logic is_nvol_set  = cmd_in.valid && cmd_in.op == fslk_pkg::OP_NVOL_SET;
    wire logic is_nvol_clr  = cmd_in.valid && cmd_in.op == fslk_pkg::OP_NVOL_CLEAR;
    wire logic is_vol_clr   = cmd_in.valid && cmd_in.op == fslk_pkg::OP_VOL_CLRALL;
    wire logic is_vol_set   = cmd_in.valid && cmd_in.op == fslk_pkg::OP_VOL_SETALL;
    wire logic is_vol_rd    = cmd_in.valid && cmd_in.op == fslk_pkg::OP_VOL_READ;
    wire logic is_nvol_rd   = cmd_in.valid && cmd_in.op == fslk_pkg::OP_NVOL_READ;
    wire logic data_ok      = cmd_in.data == fslk_pkg::LOCK_OFF ||
                              cmd_in.data == fslk_pkg::LOCK_ON;
    // guard high or guard low with wp low locks status and nonvolatile writes
    wire logic nv_open      = write_enable_latch_q && !status_guard_high &&
                              !(status_guard_low && !wp_sync_q);
    wire logic vol_wr_ok    = is_vol_wr && write_enable_latch_q && data_ok;
    wire logic vol_all_ok   = (is_vol_clr || is_vol_set) && write_enable_latch_q;
    wire logic nvol_set_ok  = is_nvol_set && nv_open;
    wire logic nvol_clr_ok  = is_nvol_clr && nv_open;
    wire logic sr_wr_ok     = srwr_in.valid && nv_open;
    wire logic write_done   = vol_wr_ok || vol_all_ok || nvol_set_ok || nvol_clr_ok || sr_wr_ok;
    wire logic unit_locked  = volatile_lock_q[pe_unit] || nonvolatile_lock_q[pe_unit];
    wire logic rd_bit       = is_vol_rd ? volatile_lock_q[cmd_unit] :
                                          nonvolatile_lock_q[cmd_unit];

    // status writes keep reserved and read-only bits, OTP bits only set
    wire logic [7:0] sr1_d = (sr1_nv_q & ~fslk_pkg::SR1_WR_MASK) |
                             (srwr_in.data & fslk_pkg::SR1_WR_MASK);
    wire logic [7:0] sr2_d = (sr2_nv_q & ~fslk_pkg::SR2_WR_MASK) |
                             (srwr_in.data & fslk_pkg::SR2_WR_MASK) |
                             (srwr_in.data & fslk_pkg::SR2_OTP_MASK);
    wire logic [7:0] sr3_d = (sr3_nv_q & ~fslk_pkg::SR3_WR_MASK) |
                             (srwr_in.data & fslk_pkg::SR3_WR_MASK);

    // ------------------------------------------------------------------
    // lock arrays
    // ------------------------------------------------------------------
    // one flop per unit: only 00h and FFh exist, so a byte collapses to a bit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            volatile_lock_q    <= {NUM_UNITS{volatile_lock_default_in}};
            nonvolatile_lock_q <= '0;
        end else begin
            if (vol_all_ok) begin
                volatile_lock_q <= {NUM_UNITS{is_vol_set}};
            end else if (vol_wr_ok) begin
                volatile_lock_q[cmd_unit] <= cmd_in.data[0];
            end
            if (nvol_clr_ok) begin
                nonvolatile_lock_q <= '0;
            end else if (nvol_set_ok) begin
                nonvolatile_lock_q[cmd_unit] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // write latch, status bytes, pin sync
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            write_enable_latch_q <= 1'b0;
            sr1_nv_q  <= fslk_pkg::NV_SR_RESET;
            sr2_nv_q  <= fslk_pkg::NV_SR_RESET;
            sr3_nv_q  <= fslk_pkg::NV_SR_RESET;
            wp_meta_q <= 1'b1;
            wp_sync_q <= 1'b1;
        end else begin
            wp_meta_q <= wp_n_in;
            wp_sync_q <= wp_meta_q;
            if (write_enable_in) begin
                write_enable_latch_q <= 1'b1;
            end else if (write_disable_in || write_done) begin
                write_enable_latch_q <= 1'b0;
            end
            if (sr_wr_ok && srwr_in.sel == fslk_pkg::SEL_SR1) begin
                sr1_nv_q <= sr1_d;
            end
            if (sr_wr_ok && srwr_in.sel == fslk_pkg::SEL_SR2) begin
                sr2_nv_q <= sr2_d;
            end
            if (sr_wr_ok && srwr_in.sel == fslk_pkg::SEL_SR3) begin
                sr3_nv_q <= sr3_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // answers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rd_data_out   <= fslk_pkg::LOCK_OFF;
            rd_valid_out  <= 1'b0;
            pe_grant_out  <= 1'b0;
            pe_reject_out <= 1'b0;
            status_out    <= fslk_pkg::STATUS_RESET;
        end else begin
            rd_valid_out  <= is_vol_rd || is_nvol_rd;
            if (is_vol_rd || is_nvol_rd) begin
                rd_data_out <= rd_bit ? fslk_pkg::LOCK_ON : fslk_pkg::LOCK_OFF;
            end
            pe_grant_out  <= pe_req_in && write_enable_latch_q && !unit_locked;
            pe_reject_out <= pe_req_in && !(write_enable_latch_q && !unit_locked);
            status_out    <= {sr3_nv_q[7:5], sr3_nv_q[4], addr4_in, sr3_nv_q[2:0],
                              erase_susp_in, sr2_nv_q[6:3], prog_susp_in, 1'b1,
                              sr2_nv_q[0], sr1_nv_q[7:2],
                              write_enable_latch_q, busy_in};
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_bad_vol_write;
        is_vol_wr && write_enable_latch_q && !data_ok && !write_enable_in;
    endsequence

    a_bad_data_keeps: assert property (s_bad_vol_write |=> write_enable_latch_q)
        else $error("bad lock data cleared the write latch");
    a_bad_data_drop: assert property (
        s_bad_vol_write |=> volatile_lock_q == $past(volatile_lock_q))
        else $error("bad lock data changed a volatile lock");
    a_nvol_clear_all: assert property (
        is_nvol_clr && nv_open |=> nonvolatile_lock_q == '0)
        else $error("nonvolatile clear left a lock set");
    a_no_latch_hold: assert property (
        !write_enable_latch_q && !write_enable_in |=>
        volatile_lock_q == $past(volatile_lock_q) &&
        nonvolatile_lock_q == $past(nonvolatile_lock_q))
        else $error("lock changed without write latch");
    a_read_value: assert property (
        rd_valid_out |-> rd_data_out == fslk_pkg::LOCK_ON || rd_data_out == fslk_pkg::LOCK_OFF)
        else $error("lock read gave an unsupported value");
    a_read_latency: assert property (
        is_nvol_rd && nonvolatile_lock_q[cmd_unit] |=>
        rd_valid_out && rd_data_out == fslk_pkg::LOCK_ON)
        else $error("nonvolatile read missed a set lock");
    a_locked_reject: assert property (
        pe_req_in && unit_locked |=> pe_reject_out && !pe_grant_out)
        else $error("locked unit was granted program or erase");
    a_guard_high: assert property (
        status_guard_high && is_nvol_set |=> nonvolatile_lock_q == $past(nonvolatile_lock_q))
        else $error("nonvolatile lock written under guard high");
    a_quad_fixed: assert property (status_out[9] == 1'b1)
        else $error("quad enable bit not held at one");
    a_reserved_hold: assert property (
        srwr_in.valid |=> sr3_nv_q[7:5] == $past(sr3_nv_q[7:5]) &&
        sr3_nv_q[3] == $past(sr3_nv_q[3]))
        else $error("status write changed a reserved bit");
endmodule : fslk_core

// ---- fslk_host_model.sv ----
// host model that issues decoded lock, status and check requests
`timescale 1ns/100ps
module fslk_host_model (
    // clock
    input  wire logic                   clk_in,
    // requests towards the lock block
    output fslk_pkg::fslk_cmd_t         cmd_out,
    output fslk_pkg::fslk_srwr_t        srwr_out,
    output logic                        wren_out,
    output logic                        wrdi_out,
    output logic                        pe_req_out,
    output logic [fslk_pkg::ADDR_W-1:0] pe_addr_out
);
    initial begin
        cmd_out = '0;
        srwr_out = '0;
        wren_out = 1'b0;
        wrdi_out = 1'b0;
        pe_req_out = 1'b0;
        pe_addr_out = '0;
    end
    // kind: 0 command, 1 status write, 2 write enable, 3 write disable, 4 protect check
    // released fields show the inverse so a stale value is never mistaken for a live one
    task automatic req(input int k, input logic [7:0] op, input logic [27:0] a,
                       input logic [7:0] d);
        @(posedge clk_in);
        #2;
        cmd_out = '{(k == 0), op, a, d};
        srwr_out = '{(k == 1), op[1:0], d};
        wren_out = (k == 2);
        wrdi_out = (k == 3);
        pe_req_out = (k == 4);
        pe_addr_out = a;
        @(posedge clk_in);
        #2;
        cmd_out = '{1'b0, ~op, ~a, ~d};
        srwr_out = '{1'b0, ~op[1:0], ~d};
        wren_out = 1'b0;
        wrdi_out = 1'b0;
        pe_req_out = 1'b0;
        pe_addr_out = ~a;
    endtask : req
endmodule : fslk_host_model

// ---- fslk_core_tb.sv ----
// self-checking bench for the sector lock arrays and status bytes
`timescale 1ns/100ps
module fslk_core_tb;
    localparam logic [27:0] A_S2  = 28'h0002000;
    localparam logic [27:0] A_S3  = 28'h0003000;
    localparam logic [27:0] A_MID = 28'h0051234;
    localparam logic [27:0] A_TOP = 28'hFFF1000;
    logic                        clk_in = 1'b0;
    logic                        rst_n_in = 1'b0;
    logic                        lock_dflt = 1'b1;
    logic                        busy_in = 1'b0;
    logic                        erase_susp_in = 1'b0;
    logic                        prog_susp_in = 1'b0;
    logic                        addr4_in = 1'b0;
    logic                        wp_n_in = 1'b1;
    fslk_pkg::fslk_cmd_t         cmd;
    fslk_pkg::fslk_srwr_t        srwr;
    logic                        wren, wrdi, pe_req, pe_grant, pe_reject, rd_valid;
    logic [fslk_pkg::ADDR_W-1:0] pe_addr;
    logic [7:0]                  rd_data;
    logic [23:0]                 status;
    int                          n_errors = 0;
    int                          tests_run = 0;
    always #12.5 clk_in = ~clk_in;
    fslk_host_model u_host (.clk_in(clk_in), .cmd_out(cmd), .srwr_out(srwr), .wren_out(wren),
        .wrdi_out(wrdi), .pe_req_out(pe_req), .pe_addr_out(pe_addr));
    fslk_core u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd), .srwr_in(srwr),
        .write_enable_in(wren), .write_disable_in(wrdi), .volatile_lock_default_in(lock_dflt),
        .busy_in(busy_in), .erase_susp_in(erase_susp_in), .prog_susp_in(prog_susp_in),
        .addr4_in(addr4_in), .wp_n_in(wp_n_in), .pe_req_in(pe_req), .pe_addr_in(pe_addr),
        .pe_grant_out(pe_grant), .pe_reject_out(pe_reject), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .status_out(status));
    // ------------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------------
    task automatic do_reset(input logic dflt);
        @(posedge clk_in);
        #2;
        rst_n_in = 1'b0;
        lock_dflt = dflt;
        repeat (20) @(posedge clk_in);
        #2;
        rst_n_in = 1'b1;
    endtask : do_reset
    task automatic wren_pulse();
        u_host.req(2, 8'h00, 28'h0000000, 8'h00);
    endtask : wren_pulse
    task automatic rd(input logic [7:0] op, input logic [27:0] a, input logic [7:0] exp);
        u_host.req(0, op, a, 8'h00);
        tests_run++;
        if ({rd_valid, rd_data} !== {1'b1, exp}) begin
            n_errors++;
            $display("ERROR lock read %h at %h expected %h seen %b %h", op, a, exp,
                     rd_valid, rd_data);
        end
    endtask : rd
    task automatic chk_st(input logic [23:0] exp);
        repeat (2) @(posedge clk_in);
        #2;
        tests_run++;
        if (status !== exp) begin
            n_errors++;
            $display("ERROR status expected %h seen %h", exp, status);
        end
    endtask : chk_st
    task automatic chk_pe(input logic [27:0] a, input logic grant);
        u_host.req(4, 8'h00, a, 8'h00);
        tests_run++;
        if ({pe_grant, pe_reject} !== {grant, ~grant}) begin
            n_errors++;
            $display("ERROR check at %h expected %b seen %b%b", a, grant, pe_grant, pe_reject);
        end
    endtask : chk_pe
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (6000) @(posedge clk_in);
        n_errors++;
        summarize();
    end
    initial begin
        do_reset(1'b1);
        chk_st(24'h000200);
        rd(fslk_pkg::OP_VOL_READ, A_S3, 8'hFF);
        rd(fslk_pkg::OP_NVOL_READ, A_S3, 8'h00);
        u_host.req(0, fslk_pkg::OP_VOL_CLRALL, A_S3, 8'h00);
        rd(fslk_pkg::OP_VOL_READ, A_MID, 8'hFF);
        $display("test reset and latch done");
        wren_pulse();
        u_host.req(0, fslk_pkg::OP_VOL_SETALL, A_S3, 8'h00);
        wren_pulse();
        u_host.req(0, fslk_pkg::OP_VOL_CLRALL, A_S3, 8'h00);
        rd(fslk_pkg::OP_VOL_READ, A_MID, 8'h00);
        rd(fslk_pkg::OP_VOL_READ, A_S3, 8'h00);
        wren_pulse();
        u_host.req(0, fslk_pkg::OP_VOL_WRITE, A_TOP, 8'h5A);
        chk_st(24'h000202);
        rd(fslk_pkg::OP_VOL_READ, A_TOP, 8'h00);
        u_host.req(0, fslk_pkg::OP_VOL_WRITE, A_TOP, 8'hFF);
        rd(fslk_pkg::OP_VOL_READ, A_TOP, 8'hFF);
        rd(fslk_pkg::OP_VOL_READ, 28'hFFF2000, 8'h00);
        chk_st(24'h000200);
        $display("test volatile locks done");
        wren_pulse();
        u_host.req(0, fslk_pkg::OP_NVOL_SET, A_S3, 8'h00);
        wren_pulse();
        u_host.req(0, fslk_pkg::OP_NVOL_SET, A_MID, 8'h00);
        rd(fslk_pkg::OP_NVOL_READ, A_S3, 8'hFF);
        rd(fslk_pkg::OP_NVOL_READ, A_S2, 8'h00);
        rd(fslk_pkg::OP_NVOL_READ, 28'h005F000, 8'hFF);
        rd(fslk_pkg::OP_NVOL_READ, 28'h0060000, 8'h00);
        rd(fslk_pkg::OP_VOL_READ, A_S3, 8'h00);
        wren_pulse();
        chk_pe(A_S3, 1'b0);
        chk_pe(A_TOP, 1'b0);
        chk_pe(A_S2, 1'b1);
        chk_pe(A_S2, 1'b1);
        u_host.req(3, 8'h00, A_S2, 8'h00);
        chk_pe(A_S2, 1'b0);
        u_host.req(0, fslk_pkg::OP_NVOL_SET, A_S2, 8'h00);
        rd(fslk_pkg::OP_NVOL_READ, A_S2, 8'h00);
        wren_pulse();
        u_host.req(0, fslk_pkg::OP_NVOL_CLEAR, A_S2, 8'h00);
        rd(fslk_pkg::OP_NVOL_READ, A_S3, 8'h00);
        rd(fslk_pkg::OP_NVOL_READ, A_MID, 8'h00);
        $display("test nonvolatile locks done");
        {busy_in, erase_susp_in, prog_susp_in, addr4_in} = 4'hF;
        chk_st(24'h088601);
        {busy_in, erase_susp_in, prog_susp_in, addr4_in} = 4'h0;
        wren_pulse();
        u_host.req(1, 8'h02, A_S2, 8'hFF);
        chk_st(24'h130200);
        wren_pulse();
        u_host.req(1, 8'h00, A_S2, 8'hFF);
        chk_st(24'h1302FC);
        wp_n_in = 1'b0;
        repeat (3) @(posedge clk_in);
        wren_pulse();
        u_host.req(0, fslk_pkg::OP_NVOL_SET, A_S2, 8'h00);
        rd(fslk_pkg::OP_NVOL_READ, A_S2, 8'h00);
        wp_n_in = 1'b1;
        repeat (3) @(posedge clk_in);
        u_host.req(1, 8'h00, A_S2, 8'h00);
        u_host.req(1, 8'h00, A_S2, 8'h00);
        chk_st(24'h130200);
        wren_pulse();
        u_host.req(1, 8'h01, A_S2, 8'hFF);
        chk_st(24'h137B00);
        wren_pulse();
        u_host.req(1, 8'h01, A_S2, 8'h00);
        chk_st(24'h137B02);
        u_host.req(0, fslk_pkg::OP_NVOL_SET, A_S2, 8'h00);
        rd(fslk_pkg::OP_NVOL_READ, A_S2, 8'h00);
        $display("test status bytes done");
        do_reset(1'b0);
        chk_st(24'h000200);
        rd(fslk_pkg::OP_VOL_READ, A_TOP, 8'h00);
        $display("test second reset done");
        summarize();
    end
endmodule : fslk_core_tb
